// >>> core/boot_reset_map.svh
`ifndef BOOT_RESET_MAP_SVH
`define BOOT_RESET_MAP_SVH
// Boot strap codes, {eprom, link, select}
`define BOOT_CODE_HOST 3'b001
`define BOOT_CODE_LINK 3'b011
`define BOOT_CODE_NONE 3'b000
`define BOOT_CODE_RSVD 3'b010
// Reset vector of program memory
`define RESET_VECTOR 32'h0002_0004
// Scan chain length and identity
`define SCAN_LEN 8
`define IR_LEN 4
`define IR_BYPASS 4'hf
`define IR_EXTEST 4'h0
`define IR_SAMPLE 4'h1
`define IR_IDCODE 4'h2
`define IR_RESET 4'h1
`endif

// >>> core/boot_reset_pkg.sv
package boot_reset_pkg;
  typedef enum logic [2:0] {
    BOOT_NONE, BOOT_HOST, BOOT_LINK, BOOT_EPROM, BOOT_RESERVED
  } boot_mode_t;
  typedef enum {
    T_RESET, T_IDLE, T_SEL_DR, T_CAP_DR, T_SH_DR, T_EX1_DR, T_PA_DR, T_EX2_DR, T_UP_DR,
    T_SEL_IR, T_CAP_IR, T_SH_IR, T_EX1_IR, T_PA_IR, T_EX2_IR, T_UP_IR
  } tap_state_t;
endpackage : boot_reset_pkg

// >>> core/boot_reset_tap.sv
`timescale 1ns/10ps
`include "boot_reset_map.svh"
//------------------------------------------------------------
// Behaviour
// - Strap 001 host boot, 011 link boot, 000 no boot from external memory.
// - Strap 10x selects EPROM boot; boot select pin drives EPROM chip select.
// - Instructions run one per core clock, no multiplication or division.
// - Reset puts all state in a known condition, then fetch from vector.
// - Test logic is clocked from the core clock; test clock edges are found through a synchroniser.
// - Test mode select steps the test state machine.
// - Scan data shifts in on data input, out on data output.
// - Test reset low resets the test state machine.
//------------------------------------------------------------
module boot_reset_tap
  import boot_reset_pkg::*;
(
  input wire logic clk, // Core clock, one instruction per edge
  input wire logic nrst, // Processor reset, asynchronous, active low
  input wire logic eprom_boot_strap, // Strap pin
  input wire logic link_boot_strap, // Strap pin
  input wire logic boot_memory_select_in, // Boot select pin, input level
  output logic boot_memory_select_out, // Boot select pin, EPROM chip select (low)
  output logic boot_memory_select_oe, // High while driving boot select pin
  output boot_mode_t boot_mode, // Decoded boot mode
  output logic [31:0] fetch_addr, // Program fetch address
  output logic fetch_valid, // Fetch enable, one per cycle after reset
  input wire logic tck, // Test clock pin
  input wire logic tms, // Test mode select pin
  input wire logic tdi, // Test data input pin
  input wire logic test_rst_n, // Test reset pin, active low
  input wire logic [`SCAN_LEN-1:0] scan_pins, // Pin levels captured by scan
  output logic tdo, // Test data output
  output logic tdo_oe, // High while shift states drive data output
  output logic [`SCAN_LEN-1:0] scan_update, // Updated boundary outputs
  output logic emulation_status_out_n, // Open-drain status, always released
  output logic emulation_status_oe // High while pulling status low
);
  typedef struct packed {
    logic [2:0] tck_s;
    logic [1:0] tms_s;
    logic [1:0] tdi_s;
    logic [1:0] trst_s;
    logic [2:0] strap_s0;
    logic [2:0] strap_s1;
    logic sampled;
    boot_mode_t mode;
    logic [31:0] pc;
    logic run;
    logic [1:0] fill;
    tap_state_t tap;
    logic [`IR_LEN-1:0] ir;
    logic [`IR_LEN-1:0] ir_sh;
    logic [`SCAN_LEN-1:0] bsr;
    logic [`SCAN_LEN-1:0] upd;
    logic byp;
    logic tdo;
    logic tdo_oe;
  } state_t;

  state_t s_reg, s_next;

  function automatic boot_mode_t decode_straps(input logic [2:0] st);
    casez (st)
      `BOOT_CODE_HOST: decode_straps = BOOT_HOST;
      `BOOT_CODE_LINK: decode_straps = BOOT_LINK;
      `BOOT_CODE_NONE: decode_straps = BOOT_NONE;
      3'b10?: decode_straps = BOOT_EPROM;
      default: decode_straps = BOOT_RESERVED;
    endcase
  endfunction : decode_straps

  function automatic tap_state_t tap_step(input tap_state_t t, input logic m);
    case (t)
      T_RESET: tap_step = m ? T_RESET : T_IDLE;
      T_IDLE: tap_step = m ? T_SEL_DR : T_IDLE;
      T_SEL_DR: tap_step = m ? T_SEL_IR : T_CAP_DR;
      T_CAP_DR: tap_step = m ? T_EX1_DR : T_SH_DR;
      T_SH_DR: tap_step = m ? T_EX1_DR : T_SH_DR;
      T_EX1_DR: tap_step = m ? T_UP_DR : T_PA_DR;
      T_PA_DR: tap_step = m ? T_EX2_DR : T_PA_DR;
      T_EX2_DR: tap_step = m ? T_UP_DR : T_SH_DR;
      T_UP_DR: tap_step = m ? T_SEL_DR : T_IDLE;
      T_SEL_IR: tap_step = m ? T_RESET : T_CAP_IR;
      T_CAP_IR: tap_step = m ? T_EX1_IR : T_SH_IR;
      T_SH_IR: tap_step = m ? T_EX1_IR : T_SH_IR;
      T_EX1_IR: tap_step = m ? T_UP_IR : T_PA_IR;
      T_PA_IR: tap_step = m ? T_EX2_IR : T_PA_IR;
      T_EX2_IR: tap_step = m ? T_UP_IR : T_SH_IR;
      T_UP_IR: tap_step = m ? T_SEL_DR : T_IDLE;
      default: tap_step = T_RESET;
    endcase
  endfunction : tap_step

  logic tck_rise, tck_fall, trst_low;
  assign tck_rise = s_reg.tck_s[1] & ~s_reg.tck_s[2];
  assign tck_fall = ~s_reg.tck_s[1] & s_reg.tck_s[2];
  assign trst_low = ~s_reg.trst_s[1];

  //------------------------------------------------------------
  // Next state
  //------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // Pin synchronisers; test clock stage 1 also feeds stage 2 for edge detection
    s_next.tck_s = {s_reg.tck_s[1:0], tck};
    s_next.tms_s = {s_reg.tms_s[0], tms};
    s_next.tdi_s = {s_reg.tdi_s[0], tdi};
    s_next.trst_s = {s_reg.trst_s[0], test_rst_n};
    s_next.strap_s0 = {eprom_boot_strap, link_boot_strap, boot_memory_select_in};
    s_next.strap_s1 = s_reg.strap_s0;
    // Latch straps once, after the synchronisers have filled
    if (!s_reg.sampled && s_reg.run) begin
      s_next.mode = decode_straps(s_reg.strap_s1);
      s_next.sampled = 1'b1;
    end
    // One fetch per core clock; vector taken from reset
    // Run waits until both strap stages hold levels taken after release
    s_next.fill = {s_reg.fill[0], 1'b1};
    s_next.run = s_reg.fill[1];
    if (s_reg.run && s_reg.sampled) begin
      s_next.pc = s_reg.pc + 32'h0000_0001;
    end
    if (trst_low) begin
      s_next.tap = T_RESET;
      s_next.ir = `IR_IDCODE;
      s_next.tdo_oe = 1'b0;
    end else if (tck_rise) begin
      s_next.tap = tap_step(s_reg.tap, s_reg.tms_s[1]);
      case (s_reg.tap)
        T_RESET: s_next.ir = `IR_IDCODE;
        T_CAP_DR: s_next.bsr = scan_pins;
        T_SH_DR: begin
          s_next.bsr = {s_reg.tdi_s[1], s_reg.bsr[`SCAN_LEN-1:1]};
          s_next.byp = s_reg.tdi_s[1];
        end
        T_UP_DR: if (s_reg.ir == `IR_EXTEST) s_next.upd = s_reg.bsr;
        T_CAP_IR: s_next.ir_sh = `IR_LEN'(`IR_RESET);
        T_SH_IR: s_next.ir_sh = {s_reg.tdi_s[1], s_reg.ir_sh[`IR_LEN-1:1]};
        T_UP_IR: s_next.ir = s_reg.ir_sh;
        default: s_next.ir = s_reg.ir;
      endcase
    end else if (tck_fall) begin
      // Data output changes on the falling test clock edge
      // Test clock must stay high and low for three core clocks each
      s_next.tdo_oe = (s_reg.tap == T_SH_DR) || (s_reg.tap == T_SH_IR);
      if (s_reg.tap == T_SH_IR) s_next.tdo = s_reg.ir_sh[0];
      else if (s_reg.ir == `IR_BYPASS) s_next.tdo = s_reg.byp;
      else s_next.tdo = s_reg.bsr[0];
    end
  end

  //------------------------------------------------------------
  // State register
  //------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.tap <= T_RESET;
      s_reg.ir <= `IR_IDCODE;
      s_reg.mode <= BOOT_NONE;
      s_reg.pc <= `RESET_VECTOR;
      s_reg.trst_s <= 2'b00;
    end else begin
      s_reg <= s_next;
    end
  end

  //------------------------------------------------------------
  // Outputs
  //------------------------------------------------------------
  assign boot_mode = s_reg.mode;
  assign boot_memory_select_oe = s_reg.sampled && (s_reg.mode == BOOT_EPROM);
  assign boot_memory_select_out = ~s_reg.sampled;
  assign fetch_addr = s_reg.pc;
  assign fetch_valid = s_reg.run && s_reg.sampled;
  assign tdo = s_reg.tdo;
  assign tdo_oe = s_reg.tdo_oe;
  assign scan_update = s_reg.upd;
  assign emulation_status_out_n = 1'b0;
  assign emulation_status_oe = 1'b0;

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  mode_fixed_a: assert property (@(posedge clk) disable iff (!nrst)
    s_reg.sampled |=> $stable(boot_mode)) else $error("boot mode changed");
  eprom_drive_a: assert property (@(posedge clk) disable iff (!nrst)
    boot_memory_select_oe |-> boot_mode == BOOT_EPROM) else $error("select driven");
  pc_step_a: assert property (@(posedge clk) disable iff (!nrst)
    fetch_valid ##1 fetch_valid |-> fetch_addr == $past(fetch_addr) + 32'h1)
    else $error("fetch not one per cycle");
  tap_reset_a: assert property (@(posedge clk) disable iff (!nrst)
    trst_low |=> s_reg.tap == T_RESET) else $error("test reset ignored");
  tap_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !tck_rise && !trst_low |=> $stable(s_reg.tap)) else $error("state moved without tck");
  shift_in_a: assert property (@(posedge clk) disable iff (!nrst)
    tck_rise && !trst_low && s_reg.tap == T_SH_DR |=>
    s_reg.bsr[`SCAN_LEN-1] == $past(s_reg.tdi_s[1])) else $error("scan shift wrong");
  vector_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(fetch_valid) |-> fetch_addr == `RESET_VECTOR) else $error("bad vector");
  oe_shift_a: assert property (@(posedge clk) disable iff (!nrst)
    tdo_oe |-> s_reg.tap inside {T_SH_DR, T_SH_IR, T_EX1_DR, T_EX1_IR})
    else $error("tdo driven outside shift");
  select_low_a: assert property (@(posedge clk) disable iff (!nrst)
    boot_memory_select_oe |-> !boot_memory_select_out)
    else $error("chip select not low while driven");
  strap_latch_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(s_reg.run) |=> $rose(fetch_valid))
    else $error("straps not latched after run");
  oe_trst_a: assert property (@(posedge clk) disable iff (!nrst)
    trst_low |=> !tdo_oe)
    else $error("tdo driven in test reset");
  capture_dr_a: assert property (@(posedge clk) disable iff (!nrst)
    tck_rise && !trst_low && s_reg.tap == T_CAP_DR |=> s_reg.bsr == $past(scan_pins))
    else $error("scan capture wrong");
endmodule : boot_reset_tap

// >>> sim/jtag_probe_model.sv
`timescale 1ns/10ps
//--------------------------------
// Emulator probe on the test port
//--------------------------------
module jtag_probe_model (
  output logic tck, // Test clock, still between frames
  output logic tms, // Mode select
  output logic tdi, // Serial data in
  output logic test_rst_n, // Test reset, active low
  input wire logic tdo // Serial data out
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    test_rst_n = 1'b0;
  end
  // No core clock link: synchronous multi-processor control is unused
  // Slower than the board rate so the core clock sees every edge
  task automatic tick(input logic m, input logic d, output logic seen);
    tms = m;
    tdi = d;
    #200;
    seen = tdo;
    tck = 1'b1;
    #200;
    tck = 1'b0;
    tms = 1'b1; // Released lines sit at their pull-up
    tdi = 1'b1;
  endtask : tick
  task automatic start();
    #137;
    test_rst_n = 1'b1;
  endtask : start
  task automatic trst_pulse();
    test_rst_n = 1'b0;
    #1000;
    test_rst_n = 1'b1;
  endtask : trst_pulse
endmodule : jtag_probe_model

// >>> sim/boot_reset_tap_tb_top.sv
`timescale 1ns/10ps
`include "boot_reset_map.svh"
module boot_reset_tap_tb_top;
  import boot_reset_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, sel_out, sel_oe, fv, tck, tms, tdi, trst_n, tdo, tdo_oe;
  logic [2:0] strap = 3'h0; // {eprom, link, select}
  logic [7:0] pins = 8'h00;
  logic [7:0] upd;
  logic emu_n, emu_oe;
  logic [31:0] pc;
  boot_mode_t mode;
  int errors = 0, compares = 0, cycles = 0;
  initial forever #25 clk = ~clk;
  boot_reset_tap i_dut (.clk(clk), .nrst(nrst), .eprom_boot_strap(strap[2]),
    .link_boot_strap(strap[1]), .boot_memory_select_in(strap[0]),
    .boot_memory_select_out(sel_out), .boot_memory_select_oe(sel_oe), .boot_mode(mode),
    .fetch_addr(pc), .fetch_valid(fv), .tck(tck), .tms(tms), .tdi(tdi), .test_rst_n(trst_n),
    .scan_pins(pins), .tdo(tdo), .tdo_oe(tdo_oe), .scan_update(upd),
    .emulation_status_out_n(emu_n), .emulation_status_oe(emu_oe));
  jtag_probe_model i_probe (.tck(tck), .tms(tms), .tdi(tdi), .test_rst_n(trst_n), .tdo(tdo));
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic boot_cases();
    logic [2:0] codes [8] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h2, 3'h6, 3'h7};
    boot_mode_t exps [8] = '{BOOT_NONE, BOOT_HOST, BOOT_LINK, BOOT_EPROM, BOOT_EPROM,
      BOOT_RESERVED, BOOT_RESERVED, BOOT_RESERVED};
    int i;
    for (int c = 0; c < 8; c++) begin
      @(posedge clk) nrst <= 1'b0;
      strap <= codes[c];
      repeat (3) @(posedge clk);
      #1;
      chk("mode_in_reset", BOOT_NONE, mode);
      @(posedge clk) nrst <= 1'b1;
      i = 0;
      do begin
        @(posedge clk);
        #1;
        i++;
      end while (fv !== 1'b1 && i < 8);
      chk("fetch_addr", `RESET_VECTOR, pc);
      @(posedge clk) strap <= ~codes[c];
      #1;
      chk("fetch_addr_next", `RESET_VECTOR + 32'h1, pc);
      repeat (6) @(posedge clk);
      #1;
      chk("boot_mode", exps[c], mode);
      chk("select_oe", exps[c] == BOOT_EPROM, sel_oe);
      if (exps[c] == BOOT_EPROM) chk("select_out", 0, sel_out);
    end
  endtask : boot_cases
  task automatic scan_capture();
    logic b;
    logic [15:0] got;
    @(posedge clk) pins <= 8'h5a;
    #10;
    i_probe.trst_pulse();
    i_probe.tick(0, 1, b);
    i_probe.tick(1, 1, b);
    i_probe.tick(0, 1, b);
    i_probe.tick(0, 1, b);
    #200;
    chk("tdo_oe_shift", 1, tdo_oe);
    for (int k = 0; k < 16; k++) begin
      i_probe.tick(0, k < 8 ? 1'(8'h3c >> k) : 1'b0, b);
      got[k] = b;
    end
    chk("scan_out", {8'h3c, 8'h5a}, got);
    i_probe.trst_pulse();
    #300;
    chk("tdo_oe_after_trst", 0, tdo_oe);
    chk("scan_update", 8'h00, upd);
    chk("emu_oe", 0, emu_oe);
  endtask : scan_capture
  task automatic final_report();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  // Whole run is a few hundred cycles; this only cuts a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    i_probe.start();
    boot_cases();
    scan_capture();
    final_report();
  end
endmodule : boot_reset_tap_tb_top
